// >>> rtl/pscfg_pkg.sv
// Purpose: Constants for the parallel strap configuration decoder.
// Assumes: Eight-bit configuration images, one per register.
// Notes: Field positions follow the parallel register layout.

package pscfg_pkg;

    localparam int REG_WIDTH = 8;

    // --------------------------------------------------------------------
    // Register indices.
    // --------------------------------------------------------------------
    localparam logic [2:0] IDX_FAST_PATH_MODES = 3'h0;
    localparam logic [2:0] IDX_SIDE_CHANNEL_MODES = 3'h1;
    localparam logic [2:0] IDX_INPUT_RECEIVER_SETTINGS = 3'h2;
    localparam logic [2:0] IDX_TERM_PULSE_AB = 3'h3;
    localparam logic [2:0] IDX_TERM_PULSE_CD = 3'h4;
    localparam logic [2:0] IDX_INPUT_BOOST_AB = 3'h5;
    localparam logic [2:0] IDX_INPUT_BOOST_CD = 3'h6;
    localparam logic [2:0] IDX_OUTPUT_DRIVER_SETTINGS = 3'h7;

    // --------------------------------------------------------------------
    // Field positions.
    // --------------------------------------------------------------------
    localparam int POS_ENABLE = 6;
    localparam int POS_SOURCE_LO = 0;
    localparam int POS_RX_TERM = 0;
    localparam int POS_PREEMPH_LO = 2;
    localparam int POS_OUT_TERM = 1;
    localparam int POS_OUT_CURRENT = 0;

    // --------------------------------------------------------------------
    // Reset values, used before the straps are first sampled.
    // --------------------------------------------------------------------
    localparam logic [7:0] RST_FAST_PATH_MODES = 8'h00;
    localparam logic [7:0] RST_SIDE_CHANNEL_MODES = 8'h40;
    localparam logic [7:0] RST_INPUT_RECEIVER_SETTINGS = 8'h01;
    localparam logic [7:0] RST_TERM_PULSE = 8'h00;
    localparam logic [7:0] RST_INPUT_BOOST = 8'h00;
    localparam logic [7:0] RST_OUTPUT_DRIVER_SETTINGS = 8'h00;

    // --------------------------------------------------------------------
    // Source codes and analog level encodings.
    // --------------------------------------------------------------------
    localparam logic [1:0] SRC_A = 2'h0;
    localparam logic [1:0] SRC_B = 2'h1;
    localparam logic [1:0] SRC_C = 2'h2;
    localparam logic [1:0] SRC_D = 2'h3;
    localparam logic [3:0] EQ_LOW_DB = 4'h6;
    localparam logic [3:0] EQ_HIGH_DB = 4'hc;
    localparam logic [4:0] CURRENT_LOW_MA = 5'h0a;
    localparam logic [4:0] CURRENT_HIGH_MA = 5'h14;

    typedef enum logic [1:0] {
        PSCFG_ST_RESET = 2'b00,
        PSCFG_ST_PARALLEL = 2'b01,
        PSCFG_ST_SERIAL = 2'b11
    } pscfg_state_t;

endpackage

// >>> rtl/pscfg_source_mux.sv
// Purpose: Four-to-one selector for a group of lanes.
// Assumes: Select is already registered by the caller.
// Notes: Used for both the fast lanes and the side lines.

`timescale 1ns/1ps
`default_nettype none

module pscfg_source_mux #(
    parameter int WIDTH = 4
) (
    // Select
    input wire logic [1:0] i_select,
    // Sources
    input wire logic [WIDTH-1:0] i_src_a,
    input wire logic [WIDTH-1:0] i_src_b,
    input wire logic [WIDTH-1:0] i_src_c,
    input wire logic [WIDTH-1:0] i_src_d,
    // Result
    output logic [WIDTH-1:0] o_out
);

    assign o_out = (i_select == pscfg_pkg::SRC_A) ? i_src_a :
                   (i_select == pscfg_pkg::SRC_B) ? i_src_b :
                   (i_select == pscfg_pkg::SRC_C) ? i_src_c : i_src_d;

endmodule

`default_nettype wire

// >>> rtl/pscfg_strap_decoder.sv
// Purpose: Decodes the parallel configuration straps of a four-input
//          switch into configuration images and analog controls.
// Assumes: Straps are static and synchronous to the clock.
// Notes: A serial access hands control to the serial registers.
//
// Behaviour
// - Channel enable strap 0 turns fast channels off into standby; 1 on.
// - Source select straps route all four fast lanes of source A-D.
// - Same select routes the four side lines of A-D to common out.
// - Side switch stays enabled in parallel mode; no strap disables it.
// - Fast input terminations stay on in parallel mode.
// - Termination pulse on source switch stays off for every source.
// - One equalization strap drives every fast input channel together.
// - Equalization strap 0 gives 6 dB, 1 gives 12 dB.
// - Pre-emphasis straps 00/01/10/11 give 0/2/4/6 dB.
// - Output termination strap 0 disables, 1 enables terminations.
// - Current strap 0 gives 10 mA, 1 gives 20 mA.
// - Straps govern after reset until the first serial access.

`timescale 1ns/1ps
`default_nettype none

module pscfg_strap_decoder #(
    parameter int LANES = 4,
    parameter int SIDE_LINES = 4
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Straps
    input wire logic i_strap_channel_enable,
    input wire logic [1:0] i_strap_source_select,
    input wire logic i_strap_equalization_level,
    input wire logic [1:0] i_strap_preemphasis_level,
    input wire logic i_strap_output_termination,
    input wire logic i_strap_output_current,
    // Serial interface activity
    input wire logic i_serial_access,
    // Lane sources
    input wire logic [LANES-1:0] i_lanes_a,
    input wire logic [LANES-1:0] i_lanes_b,
    input wire logic [LANES-1:0] i_lanes_c,
    input wire logic [LANES-1:0] i_lanes_d,
    input wire logic [SIDE_LINES-1:0] i_side_a,
    input wire logic [SIDE_LINES-1:0] i_side_b,
    input wire logic [SIDE_LINES-1:0] i_side_c,
    input wire logic [SIDE_LINES-1:0] i_side_d,
    // Routed outputs
    output logic [LANES-1:0] o_lanes_out,
    output logic [SIDE_LINES-1:0] o_side_lines_common_out,
    // Configuration images
    output logic [7:0] o_fast_path_modes,
    output logic [7:0] o_side_channel_modes,
    output logic [7:0] o_input_receiver_settings,
    output logic [7:0] o_term_pulse_ab,
    output logic [7:0] o_term_pulse_cd,
    output logic [7:0] o_input_boost_ab,
    output logic [7:0] o_input_boost_cd,
    output logic [7:0] o_output_driver_settings,
    // Analog controls
    output logic o_parallel_active,
    output logic o_standby,
    output logic [3:0] o_eq_db,
    output logic [2:0] o_preemph_db,
    output logic [4:0] o_current_ma
);

    // ----------------------------------------------------------------
    // Mode tracking.
    // ----------------------------------------------------------------
    pscfg_pkg::pscfg_state_t state;
    pscfg_pkg::pscfg_state_t next_state;
    logic parallel_now;

    // Once the serial side has been touched it owns the settings until
    // the next reset; a later idle serial bus does not hand back.
    always_comb begin
        next_state = state;
        case (state)
            pscfg_pkg::PSCFG_ST_RESET: begin
                next_state = i_serial_access ? pscfg_pkg::PSCFG_ST_SERIAL
                                             : pscfg_pkg::PSCFG_ST_PARALLEL;
            end
            pscfg_pkg::PSCFG_ST_PARALLEL: begin
                if (i_serial_access) begin
                    next_state = pscfg_pkg::PSCFG_ST_SERIAL;
                end
            end
            default: begin
                next_state = pscfg_pkg::PSCFG_ST_SERIAL;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state <= pscfg_pkg::PSCFG_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign parallel_now = (next_state == pscfg_pkg::PSCFG_ST_PARALLEL);

    // ----------------------------------------------------------------
    // Strap decoding.
    // ----------------------------------------------------------------
    function automatic logic [2:0] preemph_db(input logic [1:0] code);
        preemph_db = {code, 1'b0};
    endfunction

    logic [7:0] next_fast_path_modes;
    logic [7:0] next_side_channel_modes;
    logic [7:0] next_boost;
    logic [7:0] next_driver;
    logic [LANES-1:0] lanes_sel;
    logic [SIDE_LINES-1:0] side_sel;

    assign next_fast_path_modes = {1'b0, i_strap_channel_enable, 4'h0,
                                   i_strap_source_select};
    assign next_side_channel_modes = {2'b01, 4'h0,
                                      i_strap_source_select};
    assign next_boost = {8{i_strap_equalization_level}};
    assign next_driver = {4'h0, i_strap_preemphasis_level,
                          i_strap_output_termination,
                          i_strap_output_current};

    pscfg_source_mux #(.WIDTH(LANES)) u_lane_mux (
        .i_select(o_fast_path_modes[1:0]),
        .i_src_a(i_lanes_a),
        .i_src_b(i_lanes_b),
        .i_src_c(i_lanes_c),
        .i_src_d(i_lanes_d),
        .o_out(lanes_sel)
    );

    pscfg_source_mux #(.WIDTH(SIDE_LINES)) u_side_mux (
        .i_select(o_side_channel_modes[1:0]),
        .i_src_a(i_side_a),
        .i_src_b(i_side_b),
        .i_src_c(i_side_c),
        .i_src_d(i_side_d),
        .o_out(side_sel)
    );

    // ----------------------------------------------------------------
    // Configuration images, refreshed every clock in parallel mode.
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_fast_path_modes <= pscfg_pkg::RST_FAST_PATH_MODES;
            o_side_channel_modes <= pscfg_pkg::RST_SIDE_CHANNEL_MODES;
            o_input_receiver_settings <=
                pscfg_pkg::RST_INPUT_RECEIVER_SETTINGS;
            o_term_pulse_ab <= pscfg_pkg::RST_TERM_PULSE;
            o_term_pulse_cd <= pscfg_pkg::RST_TERM_PULSE;
            o_input_boost_ab <= pscfg_pkg::RST_INPUT_BOOST;
            o_input_boost_cd <= pscfg_pkg::RST_INPUT_BOOST;
            o_output_driver_settings <=
                pscfg_pkg::RST_OUTPUT_DRIVER_SETTINGS;
        end else if (parallel_now) begin
            o_fast_path_modes <= next_fast_path_modes;
            o_side_channel_modes <= next_side_channel_modes;
            o_input_receiver_settings <=
                pscfg_pkg::RST_INPUT_RECEIVER_SETTINGS;
            o_term_pulse_ab <= pscfg_pkg::RST_TERM_PULSE;
            o_term_pulse_cd <= pscfg_pkg::RST_TERM_PULSE;
            o_input_boost_ab <= next_boost;
            o_input_boost_cd <= next_boost;
            o_output_driver_settings <= next_driver;
        end
    end

    // ----------------------------------------------------------------
    // Analog controls and routed data.
    // ----------------------------------------------------------------
    // The data paths carry one clock of latency because every output
    // of this block is registered.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_parallel_active <= 1'b0;
            o_standby <= 1'b1;
            o_eq_db <= pscfg_pkg::EQ_LOW_DB;
            o_preemph_db <= 3'h0;
            o_current_ma <= pscfg_pkg::CURRENT_LOW_MA;
            o_lanes_out <= '0;
            o_side_lines_common_out <= '0;
        end else begin
            o_parallel_active <= parallel_now;
            if (parallel_now) begin
                o_standby <= ~i_strap_channel_enable;
                o_eq_db <= i_strap_equalization_level ?
                           pscfg_pkg::EQ_HIGH_DB :
                           pscfg_pkg::EQ_LOW_DB;
                o_preemph_db <=
                    preemph_db(i_strap_preemphasis_level);
                o_current_ma <= i_strap_output_current ?
                                pscfg_pkg::CURRENT_HIGH_MA :
                                pscfg_pkg::CURRENT_LOW_MA;
            end
            o_lanes_out <= o_standby ? '0 : lanes_sel;
            o_side_lines_common_out <= side_sel;
        end
    end

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    property p_standby;
        @(posedge i_ref_clk) disable iff (i_reset)
        (parallel_now && !i_serial_access)
            |=> (o_standby == !$past(i_strap_channel_enable));
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby wrong");

    property p_lane_off;
        @(posedge i_ref_clk) disable iff (i_reset)
        o_standby |=> (o_lanes_out == '0);
    endproperty
    a_lane_off: assert property (p_lane_off)
        else $error("lanes driven in standby");

    property p_src;
        @(posedge i_ref_clk) disable iff (i_reset)
        parallel_now
            |=> o_fast_path_modes[1:0] == $past(i_strap_source_select);
    endproperty
    a_src: assert property (p_src)
        else $error("source select wrong");

    property p_side_src;
        @(posedge i_ref_clk) disable iff (i_reset)
        parallel_now
            |=> o_side_channel_modes[1:0] == $past(i_strap_source_select);
    endproperty
    a_side_src: assert property (p_side_src)
        else $error("side source select wrong");

    property p_side_en;
        @(posedge i_ref_clk) disable iff (i_reset)
        o_parallel_active
            |-> o_side_channel_modes[pscfg_pkg::POS_ENABLE];
    endproperty
    a_side_en: assert property (p_side_en)
        else $error("side off");

    property p_rx_term;
        @(posedge i_ref_clk) disable iff (i_reset)
        o_parallel_active
            |-> o_input_receiver_settings[pscfg_pkg::POS_RX_TERM];
    endproperty
    a_rx_term: assert property (p_rx_term)
        else $error("rx term off");

    property p_pulse;
        @(posedge i_ref_clk) disable iff (i_reset)
        o_parallel_active
            |-> (o_term_pulse_ab == 8'h00 && o_term_pulse_cd == 8'h00);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("pulse on");

    property p_boost;
        @(posedge i_ref_clk) disable iff (i_reset)
        parallel_now
            |=> o_input_boost_ab == {8{$past(i_strap_equalization_level)}};
    endproperty
    a_boost: assert property (p_boost)
        else $error("boost not uniform");

    property p_eq;
        @(posedge i_ref_clk) disable iff (i_reset)
        parallel_now |=>
            (o_eq_db == ($past(i_strap_equalization_level) ?
                pscfg_pkg::EQ_HIGH_DB : pscfg_pkg::EQ_LOW_DB))
            && (o_input_boost_cd
                == {8{$past(i_strap_equalization_level)}});
    endproperty
    a_eq: assert property (p_eq)
        else $error("equalization wrong");

    property p_preemph;
        @(posedge i_ref_clk) disable iff (i_reset)
        parallel_now |=>
            (o_preemph_db == {$past(i_strap_preemphasis_level), 1'b0})
            && (o_output_driver_settings[pscfg_pkg::POS_PREEMPH_LO +: 2]
                == $past(i_strap_preemphasis_level));
    endproperty
    a_preemph: assert property (p_preemph)
        else $error("preemphasis wrong");

    property p_drv;
        @(posedge i_ref_clk) disable iff (i_reset)
        parallel_now |=>
            (o_current_ma == ($past(i_strap_output_current) ?
                pscfg_pkg::CURRENT_HIGH_MA : pscfg_pkg::CURRENT_LOW_MA))
            && (o_output_driver_settings[pscfg_pkg::POS_OUT_TERM]
                == $past(i_strap_output_termination));
    endproperty
    a_drv: assert property (p_drv)
        else $error("driver wrong");

    property p_follow;
        @(posedge i_ref_clk) disable iff (i_reset)
        parallel_now |=> o_parallel_active
            && (o_fast_path_modes[pscfg_pkg::POS_ENABLE]
                == $past(i_strap_channel_enable));
    endproperty
    a_follow: assert property (p_follow)
        else $error("straps not followed");

    property p_serial_hold;
        @(posedge i_ref_clk) disable iff (i_reset)
        (state == pscfg_pkg::PSCFG_ST_SERIAL)
            |=> $stable(o_output_driver_settings) && !o_parallel_active;
    endproperty
    a_serial_hold: assert property (p_serial_hold)
        else $error("serial overridden");

endmodule

`default_nettype wire

// >>> dv/pscfg_strap_board.sv
// Purpose: Model of the board straps tied to fixed logic levels.
// Assumes: The bench reties the straps only between tests.
// Notes: Straps are plain levels with no clock of their own.

`timescale 1ns/1ps
`default_nettype none

module pscfg_strap_board (
    // Strap pins
    output logic o_channel_enable,
    output logic [1:0] o_source_select,
    output logic o_equalization_level,
    output logic [1:0] o_preemphasis_level,
    output logic o_output_termination,
    output logic o_output_current
);
    logic [7:0] pins = 8'h80;

    // A tie holds its level until the board is reworked.
    assign {o_channel_enable, o_source_select, o_equalization_level,
            o_preemphasis_level, o_output_termination,
            o_output_current} = pins;

    task automatic tie(input logic [7:0] w);
        pins = w;
    endtask
endmodule

`default_nettype wire

// >>> dv/pscfg_strap_decoder_test.sv
// Purpose: Self-checking bench for the strap decoder.
// Assumes: Strap word is {enable, source, eq, preemph, out_term, current}.
// Notes: The driver queues expectations, a monitor compares them.

`timescale 1ns/1ps
`default_nettype none

module pscfg_strap_decoder_test;
    typedef struct packed {
        logic [63:0] imgs;
        logic [3:0] eq;
        logic [2:0] pe;
        logic [4:0] cur;
        logic sb, act, chk;
        logic [3:0] ln, sd;
    } pscfg_exp_t;

    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic serial = 1'b0;
    logic [3:0] lanes [4] = '{default: 4'h0};
    logic [3:0] sides [4] = '{default: 4'h0};
    logic en, eql, oto, ocl;
    logic [1:0] src, pel;
    logic [7:0] fast, side, rx, pab, pcd, bab, bcd, drv;
    logic act, sb;
    logic [3:0] lo, so, eq;
    logic [2:0] pe;
    logic [4:0] cur;
    pscfg_exp_t q[$];
    event check_ev;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] w, last;

    always #4 i_ref_clk = ~i_ref_clk;

    pscfg_strap_board pscfg_strap_board_i (.o_channel_enable(en),
        .o_source_select(src), .o_equalization_level(eql),
        .o_preemphasis_level(pel), .o_output_termination(oto),
        .o_output_current(ocl));

    pscfg_strap_decoder pscfg_strap_decoder_i (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .i_strap_channel_enable(en),
        .i_strap_source_select(src), .i_strap_equalization_level(eql),
        .i_strap_preemphasis_level(pel), .i_strap_output_termination(oto),
        .i_strap_output_current(ocl), .i_serial_access(serial),
        .i_lanes_a(lanes[0]), .i_lanes_b(lanes[1]), .i_lanes_c(lanes[2]),
        .i_lanes_d(lanes[3]), .i_side_a(sides[0]), .i_side_b(sides[1]),
        .i_side_c(sides[2]), .i_side_d(sides[3]), .o_lanes_out(lo),
        .o_side_lines_common_out(so), .o_fast_path_modes(fast),
        .o_side_channel_modes(side), .o_input_receiver_settings(rx),
        .o_term_pulse_ab(pab), .o_term_pulse_cd(pcd),
        .o_input_boost_ab(bab), .o_input_boost_cd(bcd),
        .o_output_driver_settings(drv), .o_parallel_active(act),
        .o_standby(sb), .o_eq_db(eq), .o_preemph_db(pe),
        .o_current_ma(cur));

    // ------------------------------------------------------------
    // Expectations and checking.
    // ------------------------------------------------------------
    function automatic pscfg_exp_t expect_cfg(input logic [7:0] s,
                                              input logic a);
        pscfg_exp_t e;
        e.imgs = {1'b0, s[7], 4'h0, s[6:5], 2'b01, 4'h0, s[6:5],
                  8'h01, 16'h0000, {16{s[4]}}, 4'h0, s[3:0]};
        e.eq = s[4] ? 4'hc : 4'h6;
        e.pe = {s[3:2], 1'b0};
        e.cur = s[0] ? 5'h14 : 5'h0a;
        e.sb = ~s[7];
        e.act = a;
        e.chk = 1'b1;
        e.ln = s[7] ? lanes[s[6:5]] : 4'h0;
        e.sd = sides[s[6:5]];
        return e;
    endfunction

    function automatic pscfg_exp_t expect_rst();
        pscfg_exp_t e;
        e = '0;
        e.imgs = {8'h00, 8'h40, 8'h01, 40'h0};
        e.eq = 4'h6;
        e.cur = 5'h0a;
        e.sb = 1'b1;
        return e;
    endfunction

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    always begin
        pscfg_exp_t e;
        @(check_ev);
        e = q.pop_front();
        cmp(fast, e.imgs[63:56], "fast modes");
        cmp(side, e.imgs[55:48], "side modes");
        cmp(rx, e.imgs[47:40], "receiver");
        cmp({pab, pcd}, e.imgs[39:24], "pulse");
        cmp({bab, bcd}, e.imgs[23:8], "boost");
        cmp(drv, e.imgs[7:0], "driver");
        cmp(eq, e.eq, "equalization");
        cmp(pe, e.pe, "preemphasis");
        cmp(cur, e.cur, "current");
        cmp(sb, e.sb, "standby");
        cmp(act, e.act, "parallel active");
        if (e.chk) begin
            cmp(lo, e.ln, "lanes");
            cmp(so, e.sd, "side lines");
        end
    end

    // ------------------------------------------------------------
    // Driving and the main sequence.
    // ------------------------------------------------------------
    task automatic note(input pscfg_exp_t e);
        q.push_back(e);
        -> check_ev;
    endtask

    task automatic apply(input logic [7:0] s);
        pscfg_strap_board_i.tie(s);
        for (int k = 0; k < 4; k++) begin
            lanes[k] = 4'($urandom);
            sides[k] = 4'($urandom);
        end
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(39));
        repeat (3) @(posedge i_ref_clk);
        #1;
        note(expect_rst());
        i_reset = 1'b0;
        // Every source with both enables, every preemphasis code.
        for (int i = 0; i < 32; i++) begin
            w = {i[4], i[1:0], i[0] ^ i[4], i[3:2], i[1], i[2] ^ i[3]};
            apply(w);
            note(expect_cfg(w, 1'b1));
            last = w;
        end
        // A serial access freezes the images on the last strap value.
        serial = 1'b1;
        @(posedge i_ref_clk);
        #1;
        serial = 1'b0;
        apply(~last);
        note(expect_cfg(last, 1'b0));
        // A fresh reset hands control back to the straps.
        i_reset = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        #1;
        note(expect_rst());
        w = 8'($urandom);
        i_reset = 1'b0;
        apply(w);
        note(expect_cfg(w, 1'b1));
        @(posedge i_ref_clk);
        stop_test();
    end
endmodule

`default_nettype wire
